// [dv/atm_peer_model.sv]
// Purpose: remote station across the line
// Assumes: frames arrive as one-cycle strobes
// Notes:   released payload, snr and level lines show inverted data
`timescale 1ns/1ps
module atm_peer_model import atm_pkg::*; #(
    parameter logic [ATM_TM_W-1:0] TQ = 24'he7e7e7
) (
    input wire logic                        clk,
    // frames towards the block
    output logic                            rx_valid,
    output logic [ATM_ADDR_W-1:0]           rx_src,
    output logic                            rx_is_data,
    output logic                            rx_map_request_flag,
    output logic                            rx_is_resp,
    output logic [8*ATM_PAY_BYTES-1:0]      rx_payload,
    output logic [2:0]                      rx_fch_mod,
    output logic                            rx_fch_coh,
    output logic [7:0]                      rx_snr,
    output logic [7:0]                      rx_level,
    output logic [7:0]                      rx_lqi,
    output logic [ATM_TM_W-1:0]             rx_tone_quality,
    // responses from the block
    input wire logic                        resp_valid,
    input wire logic [ATM_ADDR_W-1:0]       resp_dest,
    input wire logic [8*ATM_PAY_BYTES-1:0]  resp_payload,
    output logic                            resp_ready
);
    int                            ready_delay = 0;
    int                            wcnt        = 0;
    int                            got_n       = 0;
    logic [8*ATM_PAY_BYTES-1:0]    got_payload = '0;
    logic [ATM_ADDR_W-1:0]         got_dest    = '0;
    initial begin
        {rx_valid, rx_src, rx_is_data, rx_map_request_flag, rx_is_resp} = '0;
        {rx_payload, rx_fch_mod, rx_fch_coh, rx_snr, rx_level, rx_lqi} = '0;
        rx_tone_quality = TQ;
        resp_ready = 1'b0;
    end
    // header and quality travel with each frame
    task automatic frame(input logic [15:0] s, input logic [2:0] kind,
                         input logic [95:0] p, input logic [7:0] snr, input logic [7:0] lvl);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_src <= s;
        {rx_is_data, rx_map_request_flag, rx_is_resp} <= kind;
        rx_payload <= p;
        {rx_fch_coh, rx_fch_mod} <= p[3:0];
        rx_snr <= snr;
        rx_level <= lvl;
        rx_lqi <= lvl ^ 8'h5a;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_payload <= ~p;
        rx_snr <= ~snr;
        rx_level <= ~lvl;
    endtask : frame
    // slow acceptance stresses the response hold
    always @(posedge clk) begin
        resp_ready <= 1'b0;
        if (resp_valid && !resp_ready) begin
            if (wcnt >= ready_delay) begin
                resp_ready <= 1'b1;
                wcnt <= 0;
            end else
                wcnt <= wcnt + 1;
        end
        if (resp_valid && resp_ready) begin
            got_payload <= resp_payload;
            got_dest <= resp_dest;
            got_n <= got_n + 1;
        end
    end
endmodule : atm_peer_model

// [dv/atm_tme_checker.sv]
// Purpose: port-level assertions for the tone map exchange
// Assumes: ce held high by the bench
// Notes:   bound to every instance of the block
`timescale 1ns/1ps
module atm_tme_checker import atm_pkg::*; (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       rstn,
    input wire logic                       ce,
    // stimulus seen
    input atm_band_e                       band,
    input wire logic                       tx_req,
    input wire logic                       tx_is_data,
    input wire logic                       rx_valid,
    input wire logic                       rx_is_data,
    input wire logic                       rx_map_request_flag,
    input wire logic                       rx_is_resp,
    input wire logic [8*ATM_PAY_BYTES-1:0] rx_payload,
    input wire logic [2:0]                 rx_fch_mod,
    input wire logic [7:0]                 rx_lqi,
    input wire logic                       resp_ready,
    // design outputs
    input wire logic                       tx_cfg_valid,
    input wire logic                       tx_map_request_flag,
    input atm_params_s                     tx_cfg,
    input wire logic                       resp_valid,
    input wire logic [8*ATM_PAY_BYTES-1:0] resp_payload,
    input wire logic                       rx_dec_valid,
    input wire logic [2:0]                 rx_dec_mod,
    input wire logic                       rx_resp_bad
);
    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // a flagged frame only counts while no response is pending
    wire flag_rx = ce && rx_valid && rx_is_data && rx_map_request_flag && !resp_valid;

    tx_answer_a: assert property (ce && tx_req |=> tx_cfg_valid)
        else $error("no transmit config after request");
    flag_kind_a: assert property (tx_cfg_valid && tx_map_request_flag |-> $past(tx_is_data))
        else $error("request flag on a non-data frame");
    flag_robust_a: assert property (tx_cfg_valid && tx_map_request_flag
        |-> tx_cfg.modulation_select == ATM_MOD_ROBUST && &tx_cfg.subband_tone_map)
        else $error("flagged frame not robust");
    resp_start_a: assert property (flag_rx |=> resp_valid)
        else $error("no response to flagged data");
    resp_none_a: assert property (ce && rx_valid && rx_is_data && !rx_map_request_flag
        && !resp_valid |=> !resp_valid)
        else $error("response without flag");
    resp_hold_a: assert property (resp_valid && !resp_ready
        |=> resp_valid && $stable(resp_payload))
        else $error("response dropped before ready");
    dec_mod_a: assert property (ce && rx_valid && rx_is_data
        |=> rx_dec_valid && rx_dec_mod == $past(rx_fch_mod))
        else $error("decode mod not from header");
    bad_mod_a: assert property (ce && rx_valid && rx_is_resp && band == ATM_BAND_FCC
        && rx_payload[2:0] > 3'h4 |=> rx_resp_bad)
        else $error("reserved code accepted");
    coef_zero_a: assert property (resp_valid && band != ATM_BAND_FCC
        |-> resp_payload[55:24] == '0)
        else $error("coefficients not zero");
    lqi_fcc_a: assert property (flag_rx && band == ATM_BAND_FCC
        |=> resp_payload[39:32] == $past(rx_lqi))
        else $error("link quality misplaced");
endmodule : atm_tme_checker

bind atm_tone_map_exchange atm_tme_checker u_atm_tme_checker (
    .clk(clk), .rstn(rstn), .ce(ce), .band(band), .tx_req(tx_req), .tx_is_data(tx_is_data),
    .rx_valid(rx_valid), .rx_is_data(rx_is_data), .rx_map_request_flag(rx_map_request_flag),
    .rx_is_resp(rx_is_resp), .rx_payload(rx_payload), .rx_fch_mod(rx_fch_mod),
    .rx_lqi(rx_lqi), .resp_ready(resp_ready), .tx_cfg_valid(tx_cfg_valid),
    .tx_map_request_flag(tx_map_request_flag), .tx_cfg(tx_cfg), .resp_valid(resp_valid),
    .resp_payload(resp_payload), .rx_dec_valid(rx_dec_valid), .rx_dec_mod(rx_dec_mod),
    .rx_resp_bad(rx_resp_bad));

// [dv/tb_atm_tone_map_exchange.sv]
// Purpose: self-checking bench for the tone map exchange
// Assumes: tick shortened to 8 cycles
// Notes:   expected payloads rebuilt from field layout
`timescale 1ns/1ps
module tb_atm_tone_map_exchange;
    import atm_pkg::*;
    localparam logic [23:0] TQ = 24'he7e7e7;
    logic clk = 1'b0, rstn, ce, gain_step_resolution, tx_req, tx_is_data, tx_is_resp;
    logic [7:0]  target_receive_level, rx_snr, rx_level, rx_lqi;
    logic [15:0] record_lifetime_setting, tx_dest, rx_src, resp_dest;
    logic        rx_valid, rx_is_data, rx_map_request_flag, rx_is_resp, rx_fch_coh;
    logic [95:0] rx_payload, resp_payload, exp_p;
    logic [2:0]  rx_fch_mod, rx_dec_mod;
    logic [23:0] rx_tone_quality;
    logic        tx_cfg_valid, tx_map_request_flag, resp_valid, resp_ready;
    logic        rx_dec_valid, rx_dec_coh, rx_resp_bad;
    atm_band_e   band;
    atm_params_s tx_cfg;
    int          mismatches = 0, total_checks = 0, n0, j;
    logic [3:0]  g;
    logic [7:0]  snrs [4] = '{8'h10, 8'h30, 8'h50, 8'h70};

    always #2.5 clk = ~clk;

    atm_tone_map_exchange #(.TICK_CYC(8)) u_atm_tone_map_exchange (.*);
    atm_peer_model #(.TQ(TQ)) u_atm_peer_model (.*);

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic conclude();
        if (mismatches == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task automatic tx_send(input logic [15:0] d, input logic dat, input logic fl,
                           input logic [2:0] m);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_dest <= d;
        tx_is_data <= dat;
        tx_is_resp <= !dat;
        @(posedge clk);
        tx_req <= 1'b0;
        @(negedge clk);
        chk(tx_cfg_valid === 1'b1 && tx_map_request_flag === fl
            && tx_cfg.modulation_select === m, "transmit config");
    endtask : tx_send

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        {rstn, tx_req, tx_is_data, tx_is_resp, gain_step_resolution} = '0;
        ce = 1'b1;
        band = ATM_BAND_CEN_A;
        target_receive_level = 8'h40;
        record_lifetime_setting = 16'h0003;
        tx_dest = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        tx_send(16'h00a1, 1'b1, 1'b0, 3'h0);
        tx_send(16'h00a1, 1'b1, 1'b1, 3'h0);
        tx_send(16'h00a1, 1'b1, 1'b1, 3'h0);
        tx_send(16'h00a1, 1'b0, 1'b0, 3'h0);
        u_atm_peer_model.frame(16'h00a1, 3'b001, {80'h0, 8'h2a, 8'had}, 8'h0, 8'h0);
        tx_send(16'h00a1, 1'b1, 1'b0, 3'h2);
        chk(tx_cfg.total_gain_steps === 4'h5 && tx_cfg.gain_step_resolution === 1'b1
            && tx_cfg.subband_tone_map[5:0] === 6'h2a && tx_cfg.coherent === 1'b0, "stored");
        repeat (40) @(posedge clk);
        tx_send(16'h00a1, 1'b1, 1'b1, 3'h0);
        u_atm_peer_model.frame(16'h00d4, 3'b100, {88'h0, 8'h0d}, 8'h70, 8'h40);
        @(negedge clk);
        chk(rx_dec_valid === 1'b1 && rx_dec_mod === 3'h5 && rx_dec_coh === 1'b0
            && resp_valid === 1'b0, "data decode");
        band = ATM_BAND_FCC;
        for (int c = 3; c < 8; c++) begin
            u_atm_peer_model.frame(16'h00c3, 3'b001, {93'h0, c[2:0]}, 8'h0, 8'h0);
            @(negedge clk);
            chk(rx_resp_bad === (c > 3), "reserved modulation code");
        end
        for (int i = 0; i < 6; i++) begin
            j = i % 4;
            band = (i < 4) ? ATM_BAND_CEN_A : (i == 4) ? ATM_BAND_CEN_B : ATM_BAND_FCC;
            gain_step_resolution = (i >= 4);
            g = {j[0], gain_step_resolution ? 3'(2 * j) : 3'(j)};
            u_atm_peer_model.ready_delay = i;
            n0 = u_atm_peer_model.got_n;
            u_atm_peer_model.frame(16'h0b00 + 16'(i), 3'b110, 96'h0, snrs[j],
                j[0] ? 8'(8'h40 + 6 * j) : 8'(8'h40 - 6 * j));
            for (int k = 0; k < 20 && u_atm_peer_model.got_n == n0; k++) @(negedge clk);
            exp_p = '0;
            if (band == ATM_BAND_FCC) begin
                exp_p[31:0] = {TQ, gain_step_resolution, g, 3'(j)};
                exp_p[39:32] = 8'(8'h40 + 6 * j) ^ 8'h5a;
            end else begin
                exp_p[7:0] = {gain_step_resolution, g, 2'(j), 1'b0};
                exp_p[13:8] = (band == ATM_BAND_CEN_B) ? {3'h0, TQ[2:0]} : TQ[5:0];
                exp_p[23:16] = (j[0] ? 8'(8'h40 + 6 * j) : 8'(8'h40 - 6 * j)) ^ 8'h5a;
            end
            chk(u_atm_peer_model.got_payload === exp_p
                && u_atm_peer_model.got_dest === 16'h0b00 + 16'(i), "response payload");
        end
        conclude();
    end
endmodule : tb_atm_tone_map_exchange

// [rtl/atm_nbr_table.sv]
// Purpose: neighbour records with validity counters
// Assumes: single-cycle lookup, one write per cycle
// Notes:   full table drops new entries
`timescale 1ns/1ps
module atm_nbr_table import atm_pkg::*; #(
    parameter int DEPTH = ATM_NBR_DEPTH
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    // lookup
    input  wire logic [ATM_ADDR_W-1:0] look_addr,
    output logic                       look_valid,
    output atm_params_s                look_params,
    // update
    input  wire logic                  wr_en,
    input  wire logic [ATM_ADDR_W-1:0] wr_addr,
    input  atm_params_s                wr_params,
    input  wire logic [ATM_TTL_W-1:0]  record_lifetime_setting,
    input  wire logic                  tick
);
    logic                  used  [DEPTH];
    logic [ATM_ADDR_W-1:0] addr  [DEPTH];
    logic [ATM_TTL_W-1:0]  record_validity_counter [DEPTH];
    atm_params_s           prm   [DEPTH];

    logic [DEPTH-1:0] look_hit;
    logic [DEPTH-1:0] wr_hit;
    logic [DEPTH-1:0] free;
    int               look_idx;
    int               wr_idx;

    always_comb begin
        look_idx = 0;
        wr_idx   = -1;
        for (int i = 0; i < DEPTH; i++) begin
            look_hit[i] = used[i] && addr[i] == look_addr;
            wr_hit[i]   = used[i] && addr[i] == wr_addr;
            free[i]     = !used[i];
            if (look_hit[i])
                look_idx = i;
        end
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (free[i])
                wr_idx = i;
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (wr_hit[i])
                wr_idx = i;
        end
    end

    assign look_valid  = |look_hit && record_validity_counter[look_idx] != '0;
    assign look_params = prm[look_idx];

    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                used[i]                    <= 1'b0;
                addr[i]                    <= '0;
                record_validity_counter[i] <= '0;
                prm[i]                     <= '0;
            end
        end else if (ce) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (wr_en && wr_idx == i) begin
                    used[i]                    <= 1'b1;
                    addr[i]                    <= wr_addr;
                    prm[i]                     <= wr_params;
                    record_validity_counter[i] <= record_lifetime_setting;
                end else if (tick && record_validity_counter[i] != '0) begin
                    record_validity_counter[i] <= record_validity_counter[i] - 1'b1;
                end
            end
        end
    end

endmodule : atm_nbr_table

// [rtl/atm_pkg.sv]
// Purpose: shared constants and carriers for the adaptive tone map exchange
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes:   payload byte layouts for both bandplan families
package atm_pkg;

    // ****************************************
    // widths and sizes
    // ****************************************
    localparam int ATM_ADDR_W      = 16;
    localparam int ATM_TM_W        = 24;
    localparam int ATM_COEF_W      = 48;
    localparam int ATM_PAY_BYTES   = 12;
    localparam int ATM_CEN_BYTES   = 7;
    localparam int ATM_CEN_TM_W    = 6;
    localparam int ATM_TTL_W       = 16;
    localparam int ATM_NBR_DEPTH   = 8;

    // ****************************************
    // byte 0 and byte 11 field positions and payload byte indices
    // ****************************************
    localparam int ATM_RES_BIT     = 7;
    localparam int ATM_GAIN_HI     = 6;
    localparam int ATM_GAIN_LO     = 3;
    localparam int ATM_SCHEME_CEN  = 0;
    localparam int ATM_SCHEME_FCC  = 7;
    localparam int ATM_LQI_CEN     = 2;
    localparam int ATM_LQI_FCC     = 4;
    localparam int ATM_COEF_CEN    = 3;
    localparam int ATM_COEF_FCC    = 5;
    localparam int ATM_SCHEME_BYTE = 11;

    // ****************************************
    // modulation codes
    // ****************************************
    localparam logic [2:0] ATM_MOD_ROBUST = 3'h0;
    localparam logic [2:0] ATM_MOD_BPSK   = 3'h1;
    localparam logic [2:0] ATM_MOD_QPSK   = 3'h2;
    localparam logic [2:0] ATM_MOD_8PSK   = 3'h3;
    localparam logic [2:0] ATM_MOD_16QAM  = 3'h4;

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [3:0]  ATM_GAIN_RST   = 4'h0;
    localparam int          ATM_TICK_US    = 1000;
    localparam int          ATM_CLK_MHZ    = 200;
    localparam int          ATM_TICK_CYC   = ATM_TICK_US * ATM_CLK_MHZ;

    typedef enum logic [1:0] {
        ATM_BAND_CEN_A,
        ATM_BAND_CEN_B,
        ATM_BAND_FCC
    } atm_band_e;

    // decoded response payload / stored neighbour parameters
    typedef struct packed {
        logic                  gain_step_resolution;
        logic [3:0]            total_gain_steps;
        logic [2:0]            modulation_select;
        logic                  coherent;
        logic [ATM_TM_W-1:0]   subband_tone_map;
        logic [ATM_COEF_W-1:0] per_group_gain_coef;
        logic [7:0]            lqi;
    } atm_params_s;

    // modulation legality for band and scheme
    function automatic logic atm_mod_legal(input atm_band_e band, input logic [2:0] m,
                                           input logic coh);
        if (band != ATM_BAND_FCC)
            return m[2] == 1'b0;
        return (m <= ATM_MOD_8PSK) || (m == ATM_MOD_16QAM && coh);
    endfunction : atm_mod_legal

endpackage : atm_pkg

// [rtl/atm_tone_map_exchange.sv]
// Purpose: adaptive tone map request and response framing
// Assumes: frame-level strobes from local MAC/PHY on clk
// Notes:   payloads travel as byte vectors, byte 0 in the low bits
`timescale 1ns/1ps

// Summary of operation
// - CENELEC two-bit modulation codes decoded
// - FCC three-bit codes; reserved codes refused
// - request frame SNR selects next modulation
// - level versus target maps to gain steps
// - total gain is sign-magnitude steps
// - each tone map bit covers sub-band
// - per-group coefficients sign-magnitude, band width
// - unimplemented coefficients sent as zero
// - scheme bit ignored without coherent support
// - received response stored in neighbour record
// - missing or expired record: flag, robust
// - flag only in data or response; tx_flag is set on data frames only
// - valid record configures transmit, no flag
// - flagged data frame triggers a response
// - responses always sent in robust mode
// - response issued as soon as possible
// - response reloads lifetime, record used
// - no response means flag next data
// - no request without sending data
// - decode data using received header parameters
// - link quality placed in response payload
// - CENELEC payload byte layout
// - FCC payload byte layout
module atm_tone_map_exchange import atm_pkg::*; #(
    parameter int          DEPTH    = ATM_NBR_DEPTH,
    parameter int          TICK_CYC = ATM_TICK_CYC,
    parameter logic        HAS_COEF = 1'b0,
    parameter logic        HAS_COH  = 1'b0,
    parameter logic [7:0]  SNR_T1   = 8'h20,
    parameter logic [7:0]  SNR_T2   = 8'h40,
    parameter logic [7:0]  SNR_T3   = 8'h60
) (
    // clock, reset, enable
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire logic                      ce,
    // configuration
    input  atm_band_e                      band,
    input  wire logic                      gain_step_resolution,
    input  wire logic [7:0]                target_receive_level,
    input  wire logic [ATM_TTL_W-1:0]      record_lifetime_setting,
    // local transmit request
    input  wire logic                      tx_req,
    input  wire logic [ATM_ADDR_W-1:0]     tx_dest,
    input  wire logic                      tx_is_data,
    input  wire logic                      tx_is_resp,
    // received frame from phy
    input  wire logic                      rx_valid,
    input  wire logic [ATM_ADDR_W-1:0]     rx_src,
    input  wire logic                      rx_is_data,
    input  wire logic                      rx_map_request_flag,
    input  wire logic                      rx_is_resp,
    input  wire logic [8*ATM_PAY_BYTES-1:0] rx_payload,
    input  wire logic [2:0]                rx_fch_mod,
    input  wire logic                      rx_fch_coh,
    input  wire logic [7:0]                rx_snr,
    input  wire logic [7:0]                rx_level,
    input  wire logic [7:0]                rx_lqi,
    input  wire logic [ATM_TM_W-1:0]       rx_tone_quality,
    // transmit configuration out
    output logic                           tx_cfg_valid,
    output logic                           tx_map_request_flag,
    output atm_params_s                    tx_cfg,
    // response frame out
    output logic                           resp_valid,
    output logic [ATM_ADDR_W-1:0]          resp_dest,
    output logic [8*ATM_PAY_BYTES-1:0]     resp_payload,
    input  wire logic                      resp_ready,
    // receive decoding
    output logic                           rx_dec_valid,
    output logic [2:0]                     rx_dec_mod,
    output logic                           rx_dec_coh,
    output logic                           rx_resp_bad
);
    // ****************************************
    // neighbour table and tick
    // ****************************************
    logic                  look_valid;
    atm_params_s           look_params;
    logic                  tick;
    logic [31:0]           tick_cnt;
    logic [DEPTH-1:0]      sent_mask;
    logic [ATM_ADDR_W-1:0] sent_addr [DEPTH];

    // ****************************************
    // response parsing
    // ****************************************
    logic                  is_fcc;
    logic [7:0]            b0;
    atm_params_s           rx_par;
    logic                  rx_par_ok;
    logic                  wr_en;

    function automatic logic [7:0] byte_of(input logic [8*ATM_PAY_BYTES-1:0] p,
                                           input int n);
        return p[8*n +: 8];
    endfunction : byte_of

    assign is_fcc = band == ATM_BAND_FCC;
    assign b0     = byte_of(rx_payload, 0);

    always_comb begin
        rx_par                      = '0;
        rx_par.gain_step_resolution = b0[ATM_RES_BIT];
        rx_par.total_gain_steps     = b0[ATM_GAIN_HI:ATM_GAIN_LO];
        if (is_fcc) begin
            rx_par.modulation_select   = b0[2:0];
            rx_par.coherent            = byte_of(rx_payload, ATM_SCHEME_BYTE)[ATM_SCHEME_FCC];
            rx_par.subband_tone_map    = rx_payload[8 +: ATM_TM_W];
            rx_par.lqi                 = byte_of(rx_payload, ATM_LQI_FCC);
            rx_par.per_group_gain_coef = rx_payload[8*ATM_COEF_FCC +: ATM_COEF_W];
        end else begin
            rx_par.modulation_select   = {1'b0, b0[2:1]};
            rx_par.coherent            = b0[ATM_SCHEME_CEN];
            rx_par.subband_tone_map    = {18'h0, rx_payload[8 +: ATM_CEN_TM_W]};
            rx_par.lqi                 = byte_of(rx_payload, ATM_LQI_CEN);
            rx_par.per_group_gain_coef = {24'h0, rx_payload[8*ATM_COEF_CEN +: 24]};
        end
        if (!HAS_COH)
            rx_par.coherent = 1'b0;
    end

    assign rx_par_ok = atm_mod_legal(band, rx_par.modulation_select, rx_par.coherent);
    assign wr_en     = ce && rx_valid && rx_is_resp && rx_par_ok;

    atm_nbr_table #(
        .DEPTH(DEPTH)
    ) u_table (
        .clk                     (clk),
        .rstn                    (rstn),
        .ce                      (ce),
        .look_addr               (tx_dest),
        .look_valid              (look_valid),
        .look_params             (look_params),
        .wr_en                   (wr_en),
        .wr_addr                 (rx_src),
        .wr_params               (rx_par),
        .record_lifetime_setting (record_lifetime_setting),
        .tick                    (tick)
    );

    assign tick = tick_cnt == 32'(TICK_CYC - 1);

    // ****************************************
    // response building
    // ****************************************
    logic [2:0]  snr_mod;
    logic [7:0]  lvl_diff;
    logic [3:0]  gain_code;
    logic [7:0]  step_db;
    logic [7:0]  steps;
    logic [8*ATM_PAY_BYTES-1:0] next_payload;
    logic        want_resp;
    logic [ATM_TM_W-1:0] tm_mask;

    assign snr_mod = rx_snr >= SNR_T3 ? ATM_MOD_8PSK :
                     rx_snr >= SNR_T2 ? ATM_MOD_QPSK :
                     rx_snr >= SNR_T1 ? ATM_MOD_BPSK : ATM_MOD_ROBUST;

    assign step_db   = gain_step_resolution ? 8'h03 : 8'h06;
    assign lvl_diff  = rx_level > target_receive_level ? rx_level - target_receive_level
                                                       : target_receive_level - rx_level;
    assign steps     = lvl_diff / step_db;
    assign gain_code = {rx_level > target_receive_level,
                        steps > 8'h07 ? 3'h7 : steps[2:0]};

    // cenelec-b keeps upper sub-bands at zero
    assign tm_mask = is_fcc ? {ATM_TM_W{1'b1}} :
                     band == ATM_BAND_CEN_B ? 24'h000007 : 24'h00003f;

    always_comb begin
        next_payload = '0;
        next_payload[ATM_RES_BIT] = gain_step_resolution;
        next_payload[ATM_GAIN_HI:ATM_GAIN_LO] = gain_code;
        if (is_fcc) begin
            next_payload[2:0] = snr_mod;
            next_payload[8 +: ATM_TM_W] = rx_tone_quality & tm_mask;
            next_payload[8*ATM_LQI_FCC +: 8] = rx_lqi;
            next_payload[8*ATM_SCHEME_BYTE + ATM_SCHEME_FCC] = HAS_COH;
        end else begin
            next_payload[2:1] = snr_mod[1:0];
            next_payload[ATM_SCHEME_CEN] = HAS_COH;
            next_payload[8 +: ATM_CEN_TM_W] = rx_tone_quality[ATM_CEN_TM_W-1:0]
                                              & tm_mask[ATM_CEN_TM_W-1:0];
            next_payload[8*ATM_LQI_CEN +: 8] = rx_lqi;
        end
        // coefficients left zero, field widths reserved
    end

    assign want_resp = rx_valid && rx_is_data && rx_map_request_flag;

    // ****************************************
    // request tracking
    // ****************************************
    logic sent_hit;
    always_comb begin
        sent_hit = 1'b0;
        for (int i = 0; i < DEPTH; i++)
            sent_hit = sent_hit | (sent_mask[i] && sent_addr[i] == tx_dest);
    end

    logic [$clog2(DEPTH)-1:0] sent_ptr;
    logic tx_flag;
    // flag while no valid record, only after data sent
    assign tx_flag = tx_is_data && !look_valid && sent_hit;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_cnt  <= '0;
            sent_mask <= '0;
            sent_ptr  <= '0;
            for (int i = 0; i < DEPTH; i++)
                sent_addr[i] <= '0;
        end else if (ce) begin
            tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
            // remember destinations that carried data
            if (tx_req && tx_is_data && !sent_hit) begin
                sent_mask[sent_ptr] <= 1'b1;
                sent_addr[sent_ptr] <= tx_dest;
                sent_ptr            <= sent_ptr + 1'b1;
            end
        end
    end

    // ****************************************
    // output registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tx_cfg_valid        <= 1'b0;
            tx_map_request_flag <= 1'b0;
            tx_cfg              <= '0;
            resp_valid          <= 1'b0;
            resp_dest           <= '0;
            resp_payload        <= '0;
            rx_dec_valid        <= 1'b0;
            rx_dec_mod          <= ATM_MOD_ROBUST;
            rx_dec_coh          <= 1'b0;
            rx_resp_bad         <= 1'b0;
        end else if (ce) begin
            tx_cfg_valid <= tx_req;
            if (tx_req) begin
                tx_map_request_flag <= tx_flag;
                if (tx_is_data && look_valid) begin
                    tx_cfg <= look_params;
                end else begin
                    tx_cfg                  <= '0;
                    tx_cfg.subband_tone_map <= '1;
                end
            end
            // response offered next cycle; held until taken
            if (want_resp && !(resp_valid && !resp_ready)) begin
                resp_valid   <= 1'b1;
                resp_dest    <= rx_src;
                resp_payload <= next_payload;
            end else if (resp_ready) begin
                resp_valid <= 1'b0;
            end
            rx_dec_valid <= rx_valid && rx_is_data;
            if (rx_valid && rx_is_data) begin
                rx_dec_mod <= rx_fch_mod;
                rx_dec_coh <= rx_fch_coh && HAS_COH;
            end
            rx_resp_bad <= rx_valid && rx_is_resp && !rx_par_ok;
        end
    end

endmodule : atm_tone_map_exchange
